// File: src/cpu_ctrl_pkg.sv
// constants and carrier types for the processor control unit
package cpu_ctrl_pkg;
   // apb register map, byte addresses
   localparam logic [7:0] CTRL_ADDR = 8'h14;
   localparam logic [7:0] STAT_ADDR = 8'h18;
   localparam int CTRL_W = 4;
   localparam logic [CTRL_W-1:0] CTRL_RST = 4'hC;
   // system clock phases, oscillator is divided by four
   localparam logic [1:0] PH_LAST = 2'h3;
   localparam logic [1:0] RES_LOW_CYCLES = 2'h3;
   localparam int CLK_NS = 20;
   localparam int MAX_STRETCH_NS = 9000;
   localparam int MAX_STRETCH_CYC = MAX_STRETCH_NS / CLK_NS;
   // synchronised pins
   localparam int NUM_PINS = 8;
   localparam int PIN_RES = 0;
   localparam int PIN_NMI = 1;
   localparam int PIN_IRQA = 2;
   localparam int PIN_IRQB = 3;
   localparam int PIN_MR = 4;
   localparam int PIN_HALT = 5;
   localparam int PIN_MP0 = 6;
   localparam int PIN_MP1 = 7;
   localparam logic [NUM_PINS-1:0] PIN_RST = 8'hFE;
   // operating modes as {mode_pin_1, mode_pin_0}
   localparam logic [1:0] MODE_EXP1 = 2'h1;
   localparam logic [1:0] MODE_EXP2 = 2'h2;
   localparam logic [1:0] MODE_SINGLE = 2'h3;
   // interrupt sources, index 0 is highest priority
   localparam int NUM_SRC = 11;
   localparam int SRC_RESET = 0;
   localparam int SRC_TRAP = 1;
   localparam int SRC_NMI = 2;
   localparam int SRC_SOFT = 3;
   localparam int SRC_EXT_A = 4;
   localparam int SRC_SERIAL = 10;
   localparam logic [0:NUM_SRC-1][15:0] VEC_TABLE = {16'hFFFE, 16'hFFEE, 16'hFFFC, 16'hFFFA, 16'hFFF8,
      16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFEC, 16'hFFEA, 16'hFFF0};
   localparam logic [15:0] ADDR_ALL_HIGH = 16'hFFFF;
   typedef enum logic [2:0] {
      SEQ_IDLE = 3'h0,
      SEQ_STACK = 3'h1,
      SEQ_VEC_HI = 3'h3,
      SEQ_VEC_LO = 3'h2,
      SEQ_LOAD = 3'h6
   } seq_t;
   typedef struct packed {
      logic hold_enable;
      logic ready_stretch_enable;
      logic ext_int_b_enable;
      logic ext_int_a_enable;
   } ctrl_t;
   typedef struct packed {
      logic [15:0] addr;
      logic addr_oe;
      logic data_oe;
      logic rw;
      logic rd_n;
      logic wr_n;
      logic opcode_fetch_n;
   } bus_pins_t;
endpackage

// File: src/cpu_reset_interrupt_bus_control.sv
// reset sequencing, interrupt arbitration and external bus control of the cpu
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ns
module cpu_reset_interrupt_bus_control (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cold_start_pin,
   input wire logic nonmask_int_n,
   input wire logic ext_int_req_a,
   input wire logic ext_int_req_b,
   input wire logic mem_ready_in,
   input wire logic hold_req_n,
   input wire logic mode_pin_0,
   input wire logic mode_pin_1,
   input wire logic capture_int,
   input wire logic compare_int,
   input wire logic overflow_int,
   input wire logic match_int,
   input wire logic rx_full,
   input wire logic overrun_framing_err,
   input wire logic tx_empty,
   input wire logic core_inst_end,
   input wire logic core_sleep,
   input wire logic core_trap,
   input wire logic soft_int,
   input wire logic core_stack_done,
   input wire logic core_mask_set,
   input wire logic core_mask_clr,
   input wire logic [15:0] core_addr,
   input wire logic core_rd,
   input wire logic core_wr,
   input wire logic core_opfetch,
   input wire logic core_internal,
   input wire logic [7:0] core_rdata,
   output cpu_ctrl_pkg::bus_pins_t ext_bus,
   output logic e_clk,
   output logic bus_avail,
   output logic internal_int_req,
   output logic wake_req,
   output logic svc_start,
   output logic pc_load,
   output logic [15:0] pc_value,
   output logic core_adv,
   output logic int_mask,
   output logic [1:0] mode_latched
);
   logic [cpu_ctrl_pkg::NUM_PINS-1:0] pins;
   logic [cpu_ctrl_pkg::NUM_PINS-1:0] s1_ff;
   logic [cpu_ctrl_pkg::NUM_PINS-1:0] s2_ff;
   logic [cpu_ctrl_pkg::NUM_PINS-1:0] s3_ff;
   logic [cpu_ctrl_pkg::NUM_PINS-1:0] lvl_ff;
   logic [1:0] ph_ff;
   logic [1:0] nxt_ph;
   logic stretch_ff;
   logic nxt_stretch;
   logic e_clk_ff;
   logic tick;
   logic [1:0] res_cnt_ff;
   logic in_reset_ff;
   logic addr_high_ff;
   logic [1:0] mode_ff;
   logic expanded;
   cpu_ctrl_pkg::ctrl_t ctrl_ff;
   cpu_ctrl_pkg::seq_t seq_ff;
   logic [15:0] vec_ff;
   logic [15:0] pc_ff;
   logic imask_ff;
   logic nmi_prev_ff;
   logic nmi_pend_ff;
   logic nmi_edge;
   logic [cpu_ctrl_pkg::NUM_SRC-1:0] src;
   logic [3:0] sel;
   logic take;
   logic halt_req;
   logic halted_ff;
   logic boundary;
   logic vec_phase;
   logic ext_rd;
   logic ext_wr;
   logic stretch_cond;
   cpu_ctrl_pkg::bus_pins_t bus_ff;
   logic bus_avail_ff;
   logic int3_ff;
   logic wake_ff;
   logic svc_ff;
   logic pc_load_ff;
   logic adv_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic apb_hit;

   assign pins = {mode_pin_1, mode_pin_0, hold_req_n, mem_ready_in, ext_int_req_b, ext_int_req_a,
      nonmask_int_n, cold_start_pin};

   // three-stage synchroniser; a level counts once stages two and three agree
   for (genvar i = 0; i < cpu_ctrl_pkg::NUM_PINS; i++)
   begin : g_sync
      always_ff @(posedge clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            s1_ff[i] <= cpu_ctrl_pkg::PIN_RST[i];
            s2_ff[i] <= cpu_ctrl_pkg::PIN_RST[i];
            s3_ff[i] <= cpu_ctrl_pkg::PIN_RST[i];
            lvl_ff[i] <= cpu_ctrl_pkg::PIN_RST[i];
         end
         else if (ce)
         begin
            s1_ff[i] <= pins[i];
            s2_ff[i] <= s1_ff[i];
            s3_ff[i] <= s2_ff[i];
            if (s2_ff[i] == s3_ff[i])
               lvl_ff[i] <= s3_ff[i];
         end
      end
   end

   assign expanded = (mode_ff != cpu_ctrl_pkg::MODE_SINGLE);
   assign vec_phase = (seq_ff == cpu_ctrl_pkg::SEQ_VEC_HI) || (seq_ff == cpu_ctrl_pkg::SEQ_VEC_LO);
   // vectors come from outside only in the fully external mode
   assign ext_rd = expanded && !halted_ff && !in_reset_ff &&
      (vec_phase ? (mode_ff == cpu_ctrl_pkg::MODE_EXP1) : (core_rd && !core_internal));
   assign ext_wr = expanded && !halted_ff && !in_reset_ff && !vec_phase && core_wr && !core_internal;
   // ready only on valid external cycles or halt
   assign stretch_cond = expanded && ctrl_ff.ready_stretch_enable && !lvl_ff[cpu_ctrl_pkg::PIN_MR] &&
      (ext_rd || ext_wr || halted_ff);
   assign nxt_ph = ph_ff + 2'h1;
   assign nxt_stretch = (ph_ff == cpu_ctrl_pkg::PH_LAST) ? stretch_cond : stretch_ff;
   assign tick = ce && (ph_ff == cpu_ctrl_pkg::PH_LAST) && !stretch_cond;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ph_ff <= 2'h0;
         stretch_ff <= 1'b0;
         e_clk_ff <= 1'b0;
      end
      else if (ce)
      begin
         ph_ff <= nxt_ph;
         stretch_ff <= nxt_stretch;
         e_clk_ff <= nxt_ph[1] | nxt_stretch;
      end
   end

   // count low cycles, force address high
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // power-on counts as a reset already held long enough
         res_cnt_ff <= cpu_ctrl_pkg::RES_LOW_CYCLES;
         in_reset_ff <= 1'b1;
         addr_high_ff <= 1'b1;
         mode_ff <= cpu_ctrl_pkg::MODE_SINGLE;
      end
      else if (tick)
      begin
         if (!lvl_ff[cpu_ctrl_pkg::PIN_RES])
         begin
            if (res_cnt_ff != cpu_ctrl_pkg::RES_LOW_CYCLES)
               res_cnt_ff <= res_cnt_ff + 2'h1;
            // shorter pulses are not a reset
            if (res_cnt_ff + 2'h1 == cpu_ctrl_pkg::RES_LOW_CYCLES)
            begin
               in_reset_ff <= 1'b1;
               addr_high_ff <= 1'b1;
            end
         end
         else
         begin
            res_cnt_ff <= 2'h0;
            addr_high_ff <= 1'b0;
            if (in_reset_ff)
            begin
               in_reset_ff <= 1'b0;
               mode_ff <= {lvl_ff[cpu_ctrl_pkg::PIN_MP1], lvl_ff[cpu_ctrl_pkg::PIN_MP0]};
            end
         end
      end
   end

   // falling edge latched, cleared when taken; a new edge wins
   assign nmi_edge = nmi_prev_ff && !lvl_ff[cpu_ctrl_pkg::PIN_NMI];
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         nmi_prev_ff <= 1'b1;
         nmi_pend_ff <= 1'b0;
      end
      else if (ce)
      begin
         nmi_prev_ff <= lvl_ff[cpu_ctrl_pkg::PIN_NMI];
         nmi_pend_ff <= nmi_edge || (nmi_pend_ff && !(take && sel == 4'(cpu_ctrl_pkg::SRC_NMI)) && !in_reset_ff);
      end
   end

   always_comb
   begin
      src = '0;
      src[cpu_ctrl_pkg::SRC_TRAP] = core_trap;
      src[cpu_ctrl_pkg::SRC_NMI] = nmi_pend_ff;
      src[cpu_ctrl_pkg::SRC_SOFT] = soft_int;
      src[4] = ctrl_ff.ext_int_a_enable && !lvl_ff[cpu_ctrl_pkg::PIN_IRQA] && !imask_ff;
      src[5] = capture_int && !imask_ff;
      src[6] = compare_int && !imask_ff;
      src[7] = overflow_int && !imask_ff;
      src[8] = match_int && !imask_ff;
      src[9] = ctrl_ff.ext_int_b_enable && !lvl_ff[cpu_ctrl_pkg::PIN_IRQB] && !imask_ff;
      src[cpu_ctrl_pkg::SRC_SERIAL] = (rx_full || overrun_framing_err || tx_empty) && !imask_ff;
      sel = 4'h0;
      for (int i = cpu_ctrl_pkg::NUM_SRC - 1; i > cpu_ctrl_pkg::SRC_RESET; i--)
         if (src[i])
            sel = 4'(i);
   end

   assign halt_req = expanded && ctrl_ff.hold_enable && !lvl_ff[cpu_ctrl_pkg::PIN_HALT];
   assign boundary = core_inst_end || core_sleep;
   // no service while halted or about to halt
   assign take = tick && (seq_ff == cpu_ctrl_pkg::SEQ_IDLE) && !in_reset_ff && !halted_ff && !halt_req &&
      boundary && (src != '0);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         seq_ff <= cpu_ctrl_pkg::SEQ_IDLE;
         vec_ff <= cpu_ctrl_pkg::VEC_TABLE[cpu_ctrl_pkg::SRC_RESET];
         pc_ff <= 16'h0000;
      end
      else if (tick)
      begin
         if (in_reset_ff)
         begin
            // reset vector fetched on release, no stacking
            seq_ff <= lvl_ff[cpu_ctrl_pkg::PIN_RES] ? cpu_ctrl_pkg::SEQ_VEC_HI : cpu_ctrl_pkg::SEQ_IDLE;
            vec_ff <= cpu_ctrl_pkg::VEC_TABLE[cpu_ctrl_pkg::SRC_RESET];
         end
         else
         begin
            unique case (seq_ff)
               cpu_ctrl_pkg::SEQ_IDLE:
               begin
                  if (take)
                  begin
                     seq_ff <= cpu_ctrl_pkg::SEQ_STACK;
                     vec_ff <= cpu_ctrl_pkg::VEC_TABLE[sel];
                  end
               end
               cpu_ctrl_pkg::SEQ_STACK:
               begin
                  if (core_stack_done)
                     seq_ff <= cpu_ctrl_pkg::SEQ_VEC_HI;
               end
               cpu_ctrl_pkg::SEQ_VEC_HI:
               begin
                  pc_ff[15:8] <= core_rdata;
                  seq_ff <= cpu_ctrl_pkg::SEQ_VEC_LO;
               end
               cpu_ctrl_pkg::SEQ_VEC_LO:
               begin
                  pc_ff[7:0] <= core_rdata;
                  seq_ff <= cpu_ctrl_pkg::SEQ_LOAD;
               end
               cpu_ctrl_pkg::SEQ_LOAD:
                  seq_ff <= cpu_ctrl_pkg::SEQ_IDLE;
               default:
                  seq_ff <= cpu_ctrl_pkg::SEQ_IDLE;
            endcase
         end
      end
   end

   // hardware set of the mask wins over a software clear
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         imask_ff <= 1'b1;
      else if (ce)
      begin
         if (in_reset_ff || (tick && seq_ff == cpu_ctrl_pkg::SEQ_STACK && core_stack_done) || core_mask_set)
            imask_ff <= 1'b1;
         else if (core_mask_clr)
            imask_ff <= 1'b0;
      end
   end

   // sleep or wait counts as a boundary and resumes after
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         halted_ff <= 1'b0;
      else if (tick)
      begin
         if (!halt_req || in_reset_ff)
            halted_ff <= 1'b0;
         else if (seq_ff == cpu_ctrl_pkg::SEQ_IDLE && boundary)
            halted_ff <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bus_ff <= '{addr: cpu_ctrl_pkg::ADDR_ALL_HIGH, addr_oe: 1'b1, data_oe: 1'b0, rw: 1'b1,
            rd_n: 1'b1, wr_n: 1'b1, opcode_fetch_n: 1'b1};
         bus_avail_ff <= 1'b0;
      end
      else if (ce)
      begin
         if (addr_high_ff)
            bus_ff.addr <= cpu_ctrl_pkg::ADDR_ALL_HIGH;
         else if (seq_ff == cpu_ctrl_pkg::SEQ_VEC_HI)
            bus_ff.addr <= vec_ff;
         else if (seq_ff == cpu_ctrl_pkg::SEQ_VEC_LO)
            bus_ff.addr <= {vec_ff[15:1], 1'b1};
         else
            bus_ff.addr <= core_addr;
         bus_ff.addr_oe <= !halted_ff;
         bus_ff.data_oe <= ext_wr;
         bus_ff.rw <= !ext_wr;
         bus_ff.rd_n <= !ext_rd;
         bus_ff.wr_n <= !ext_wr;
         bus_ff.opcode_fetch_n <= !(ext_rd && !vec_phase && core_opfetch);
         bus_avail_ff <= halted_ff;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         int3_ff <= 1'b0;
         wake_ff <= 1'b0;
         svc_ff <= 1'b0;
         pc_load_ff <= 1'b0;
         adv_ff <= 1'b0;
      end
      else if (ce)
      begin
         int3_ff <= capture_int || compare_int || overflow_int || match_int || src[cpu_ctrl_pkg::SRC_SERIAL] ||
            rx_full || overrun_framing_err || tx_empty;
         wake_ff <= (src != '0) && !halted_ff;
         svc_ff <= take;
         pc_load_ff <= tick && seq_ff == cpu_ctrl_pkg::SEQ_LOAD && !in_reset_ff;
         // core steps one system cycle only when not held
         adv_ff <= tick && !in_reset_ff && !halted_ff && seq_ff == cpu_ctrl_pkg::SEQ_IDLE;
      end
   end

   // apb slave, answers in the cycle after the first access cycle
   assign apb_hit = (paddr == cpu_ctrl_pkg::CTRL_ADDR) || (paddr == cpu_ctrl_pkg::STAT_ADDR);
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end
      else if (ce)
      begin
         pready_ff <= psel && penable && !pready_ff;
         if (psel && penable && !pready_ff)
         begin
            pslverr_ff <= !apb_hit;
            if (pwrite || !apb_hit)
               prdata_ff <= 32'h0000_0000;
            else if (paddr == cpu_ctrl_pkg::CTRL_ADDR)
               prdata_ff <= {28'h0000000, ctrl_ff};
            else
               prdata_ff <= {20'h00000, seq_ff, mode_ff, in_reset_ff, halted_ff, imask_ff, nmi_pend_ff,
                  stretch_ff, bus_avail_ff, int3_ff};
         end
         else
         begin
            pslverr_ff <= 1'b0;
         end
      end
   end

   // enables clear, stretch and halt enables set on reset
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_ff <= cpu_ctrl_pkg::CTRL_RST;
      else if (ce)
      begin
         if (in_reset_ff)
            ctrl_ff <= cpu_ctrl_pkg::CTRL_RST;
         else if (psel && penable && pready_ff && pwrite && paddr == cpu_ctrl_pkg::CTRL_ADDR)
            ctrl_ff <= pwdata[cpu_ctrl_pkg::CTRL_W-1:0];
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign ext_bus = bus_ff;
   assign e_clk = e_clk_ff;
   assign bus_avail = bus_avail_ff;
   assign internal_int_req = int3_ff;
   assign wake_req = wake_ff;
   assign svc_start = svc_ff;
   assign pc_load = pc_load_ff;
   assign pc_value = pc_ff;
   assign core_adv = adv_ff;
   assign int_mask = imask_ff;
   assign mode_latched = mode_ff;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   addr_high_hold_a: assert property (addr_high_ff && ce |=> bus_ff.addr == cpu_ctrl_pkg::ADDR_ALL_HIGH)
      else $error("address bus not all high in reset");
   e_low_phase_a: assert property ($fell(e_clk_ff) ##0 ce ##1 ce |=> e_clk_ff)
      else $error("enable low phase not two oscillator cycles");
   nmi_vector_a: assert property (take && sel == 4'(cpu_ctrl_pkg::SRC_NMI) |=> vec_ff == 16'hFFFC)
      else $error("nmi vector wrong");
   mask_gate_a: assert property (take && imask_ff |-> sel < 4'(cpu_ctrl_pkg::SRC_EXT_A))
      else $error("maskable request taken with mask set");
   mask_after_stack_a: assert property (tick && seq_ff == cpu_ctrl_pkg::SEQ_STACK && core_stack_done
      |=> imask_ff && seq_ff == cpu_ctrl_pkg::SEQ_VEC_HI)
      else $error("mask not set after stacking");
   vec_low_byte_a: assert property (seq_ff == cpu_ctrl_pkg::SEQ_VEC_LO && ce && !addr_high_ff
      |=> bus_ff.addr == {vec_ff[15:1], 1'b1})
      else $error("low vector byte not at next address");
   single_quiet_a: assert property (mode_ff == cpu_ctrl_pkg::MODE_SINGLE
      |-> bus_ff.rw && bus_ff.rd_n && bus_ff.wr_n && !halted_ff && !stretch_cond)
      else $error("bus control active in single-chip mode");
   rw_write_a: assert property (!bus_ff.wr_n |-> !bus_ff.rw && bus_ff.rd_n)
      else $error("direction not low during write strobe");
   stretch_high_a: assert property (stretch_ff |-> e_clk_ff)
      else $error("enable not high while stretched");
   ba_release_a: assert property (halted_ff && ce |=> bus_avail_ff && !bus_ff.addr_oe)
      else $error("buses not released when halted");
   halt_no_take_a: assert property (halted_ff |-> !take)
      else $error("interrupt taken while halted");

   nmi_seen_c: cover property (take && sel == 4'(cpu_ctrl_pkg::SRC_NMI));
   halt_seen_c: cover property ($rose(bus_avail_ff));
   stretch_seen_c: cover property ($rose(stretch_ff));
   vector_load_c: cover property (pc_load_ff);
endmodule

// File: verification/ext_mem_model.sv
// external memory and ready source facing the control unit
`timescale 1ns/1ns
module ext_mem_model (
   input wire logic clk,
   input wire cpu_ctrl_pkg::bus_pins_t ext_bus,
   output logic [7:0] core_rdata,
   output logic mem_ready_in
);
   logic [7:0] last_ff;
   logic [1:0] rd_cnt_ff;
   // released bus shows the inverse of the last byte, never a stale match
   assign core_rdata = ext_bus.addr_oe ? ext_bus.addr[7:0] ^ 8'hA5 : ~last_ff;
   // slow memory, ready low three clocks per read, far under the limit
   assign mem_ready_in = ext_bus.rd_n | (rd_cnt_ff == 2'h3);
   always_ff @(posedge clk)
   begin
      last_ff <= core_rdata;
      if (ext_bus.rd_n)
         rd_cnt_ff <= 2'h0;
      else if (rd_cnt_ff != 2'h3)
         rd_cnt_ff <= rd_cnt_ff + 2'h1;
   end
endmodule

// File: verification/tb_top.sv
// self-checking bench for the processor control unit
`timescale 1ns/1ns
module tb_top;
   logic clk = '0, rst_n = '0, ce = '1, psel = '0, penable = '0, pwrite = '0;
   logic [7:0] paddr = 8'h00, core_rdata;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, mem_ready_in, e_clk, bus_avail, internal_int_req, wake_req;
   logic svc_start, pc_load, core_adv, int_mask, core_mask_set = '0, core_mask_clr = '0;
   logic cold_start_pin = '0, hold_req_n = '1, mode_pin_0 = '1, mode_pin_1 = '0;
   logic core_inst_end = '1, core_sleep = '0, core_stack_done = '1, core_internal = '0;
   logic core_rd = '0, core_wr = '0, core_opfetch = '0;
   logic [15:0] core_addr = 16'h0, pc_value, lfsr_ff = 16'hE338;
   logic [11:0] req = 12'h0;
   logic [1:0] mode_latched;
   cpu_ctrl_pkg::bus_pins_t ext_bus;
   int err_total = 0, total_checks = 0;
   logic [15:0] exp_pc[$];
   logic [32:0] exp_rd[$];
   localparam logic [15:0] VT [12] = '{16'hFFEE, 16'hFFFC, 16'hFFFA, 16'hFFF8, 16'hFFF6,
      16'hFFF4, 16'hFFF2, 16'hFFEC, 16'hFFEA, 16'hFFF0, 16'hFFF0, 16'hFFF0};
   cpu_reset_interrupt_bus_control dut_u (.core_trap(req[0]), .nonmask_int_n(!req[1]),
      .soft_int(req[2]), .ext_int_req_a(!req[3]), .capture_int(req[4]), .compare_int(req[5]),
      .overflow_int(req[6]), .match_int(req[7]), .ext_int_req_b(!req[8]), .rx_full(req[9]),
      .overrun_framing_err(req[10]), .tx_empty(req[11]), .*);
   ext_mem_model mem_u (.*);
   always #10 clk = ~clk;
   function automatic logic [15:0] vd(input logic [15:0] v);
      return {v[7:0] ^ 8'hA5, (v[7:0] | 8'h01) ^ 8'hA5};
   endfunction
   function logic [15:0] rnd();
      lfsr_ff = {lfsr_ff[14:0], ^(lfsr_ff & 16'hB400)};
      return lfsr_ff;
   endfunction
   task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
      total_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task stop_test();
      if (err_total == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
      @(posedge clk);
      psel <= '1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w)
         exp_rd.push_back(e);
      @(posedge clk);
      penable <= '1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= '0;
      penable <= '0;
   endtask
   // one extra edge lets the monitor take its note first
   task wait_pc();
      for (int k = 0; k < 300 && pc_load !== 1'b1; k++) @(posedge clk);
      @(posedge clk);
   endtask
   task unmask();
      core_mask_clr <= '1;
      @(posedge clk);
      core_mask_clr <= '0;
   endtask
   task serve(input int i);
      exp_pc.push_back(vd(VT[i]));
      req[i] <= '1;
      if (i < 3)
         wait_pc();
      else
         repeat (40) @(posedge clk);
      chk("pending", i > 2, exp_pc.size());
      chk("wake", i == 0 || i == 2, wake_req);
      chk("int3", i > 3 && i != 8, internal_int_req);
      if (i > 2)
      begin
         unmask();
         wait_pc();
      end
      req[i] <= '0;
      chk("mask", 1'b1, int_mask);
   endtask
   always @(posedge clk)
   begin
      if (pc_load === 1'b1)
         chk("pc", exp_pc.size() ? exp_pc.pop_front() : 'x, pc_value);
      if (psel && penable && pready === 1'b1 && !pwrite)
         chk("apb", exp_rd.pop_front(), {pslverr, prdata});
   end
   initial
   begin
      #200000;
      err_total++;
      stop_test();
   end
   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= '1;
      exp_pc.push_back(vd(16'hFFFE));
      apb(0, cpu_ctrl_pkg::CTRL_ADDR, 0, {29'h0, cpu_ctrl_pkg::CTRL_RST});
      chk("addr", 16'hFFFF, ext_bus.addr);
      cold_start_pin <= '1;
      wait_pc();
      chk("start", 4'h9, {int_mask, bus_avail, mode_latched});
      apb(1, cpu_ctrl_pkg::CTRL_ADDR, {rnd(), 16'h000F}, 0);
      apb(0, cpu_ctrl_pkg::CTRL_ADDR, 0, 33'h0F);
      apb(0, 8'h20, 0, {1'b1, 32'h0});
      core_rd <= '1;
      core_opfetch <= '1;
      core_addr <= rnd();
      repeat (3) @(posedge clk);
      chk("rd", {4'hA, core_addr}, {ext_bus.rw, ext_bus.rd_n, ext_bus.wr_n, ext_bus.opcode_fetch_n,
         ext_bus.addr});
      core_rd <= '0;
      core_opfetch <= '0;
      core_wr <= '1;
      repeat (3) @(posedge clk);
      chk("wr", 4'h5, {ext_bus.rw, ext_bus.rd_n, ext_bus.wr_n, ext_bus.opcode_fetch_n});
      core_wr <= '0;
      hold_req_n <= '0;
      for (int k = 0; k < 300 && bus_avail !== 1'b1; k++) @(posedge clk);
      chk("halt", 3'h5, {bus_avail, ext_bus.addr_oe, ext_bus.rw});
      hold_req_n <= '1;
      for (int k = 0; k < 300 && bus_avail !== 1'b0; k++) @(posedge clk);
      for (int i = 0; i < 12; i++)
      begin
         repeat (rnd() & 3) @(posedge clk);
         serve(i);
      end
      apb(1, cpu_ctrl_pkg::CTRL_ADDR, 32'hC, 0);
      exp_pc.push_back(vd(VT[3]));
      req[3] <= '1;
      unmask();
      repeat (40) @(posedge clk);
      chk("gated", 1, exp_pc.size());
      apb(1, cpu_ctrl_pkg::CTRL_ADDR, 32'hF, 0);
      wait_pc();
      exp_pc.push_back(vd(VT[3]));
      exp_pc.push_back(vd(VT[8]));
      req[3] <= '1;
      req[8] <= '1;
      unmask();
      wait_pc();
      req[3] <= '0;
      // let the synchronised pin settle high before the mask opens
      repeat (8) @(posedge clk);
      unmask();
      wait_pc();
      req[8] <= '0;
      exp_pc.push_back(vd(16'hFFFE));
      cold_start_pin <= '0;
      repeat (20) @(posedge clk);
      chk("addr", 16'hFFFF, ext_bus.addr);
      cold_start_pin <= '1;
      wait_pc();
      apb(0, cpu_ctrl_pkg::CTRL_ADDR, 0, {29'h0, cpu_ctrl_pkg::CTRL_RST});
      stop_test();
   end
endmodule
